/* core/t1pre_top.sv */
// timer1 prescaler, clock source select and pll control registers
// assumes an ahb-lite master, fast clock strobes synchronous to hclk and a raw pll lock level
//
// Operation
// - prescaler runs from system clock or from fast peripheral clock
// - fast-clock select one picks fast clock, zero picks system clock
// - taps from undivided base clock down to divide by 16384, plus stop
// - fast clock at full rate, halved when low speed select is one
// - low speed select resets to zero
// - pll status bits 6 to 3 read zero
// - fast-clock select can be set only while the pll is enabled
// - pll enable starts the pll and the rc reference when needed
// - pll enable reads one while fuses select the pll
// - lock flag shows pll lock and may toggle during lock-in
// - writing one to bit 6 clears the prescaler, count untouched
// - prescaler clear self-clears, zero writes ignored, reads zero
// - bit 7 reserved, whole register resets to zero meaning stopped
// - code zero stops, code one undivided, each code doubles divisor
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module t1pre_top #(
   parameter int PRESC_W = t1pre_pkg::T1PRE_PRESC_W,
   parameter int CS_W = t1pre_pkg::T1PRE_CS_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [3:0] clock_source_fuses,
   input wire logic pll_locked_raw,
   input wire logic fast_periph_timebase,
   output logic pll_run,
   output logic rc_osc_enable,
   output logic [1:0] dead_time_prescale,
   output t1pre_pkg::t1pre_tclk_t timer_clk
);
   t1pre_pkg::t1pre_aphase_t ap_r;
   t1pre_pkg::t1pre_aphase_t ap_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic [CS_W-1:0] cs_r;
   logic [CS_W-1:0] cs_nxt;
   logic [1:0] dt_r;
   logic [1:0] dt_nxt;
   logic clr_r;
   logic clr_nxt;
   logic lsm_r;
   logic lsm_nxt;
   logic fsel_r;
   logic fsel_nxt;
   logic pll_enable_bit_r;
   logic pll_enable_bit_nxt;
   logic wr_presc;
   logic wr_pll;
   logic fuse_pll;
   logic pll_en_any;
   logic lock_sync;
   logic pll_lock_flag;
   t1pre_pkg::t1pre_sw_t sw_r;
   t1pre_pkg::t1pre_sw_t sw_nxt;
   logic mode_r;
   logic mode_nxt;
   logic half_r;
   logic half_nxt;
   logic pck_eff;
   logic base_tick;
   logic presc_clear;
   logic div_tick;

   if (CS_W != t1pre_pkg::T1PRE_CS_W) begin : g_chk
      $error("t1pre_top: clock select field must be four bits");
   end

   // ---------------- bus slave ----------------
   // zero wait states: the slave never stalls and always answers okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_comb begin
      ap_nxt.valid = hsel & hready & htrans[1];
      ap_nxt.write = hwrite;
      ap_nxt.hit_presc = (haddr == t1pre_pkg::T1PRE_PRESC_ADDR);
      ap_nxt.hit_pll = (haddr == t1pre_pkg::T1PRE_PLL_ADDR);
   end

   assign wr_presc = ap_r.valid & ap_r.write & ap_r.hit_presc;
   assign wr_pll = ap_r.valid & ap_r.write & ap_r.hit_pll;

   // ---------------- control registers ----------------
   assign fuse_pll = (clock_source_fuses == t1pre_pkg::T1PRE_FUSE_PLL);
   assign pll_en_any = fuse_pll | pll_enable_bit_r;

   always_comb begin
      cs_nxt = cs_r;
      dt_nxt = dt_r;
      lsm_nxt = lsm_r;
      fsel_nxt = fsel_r;
      pll_enable_bit_nxt = pll_enable_bit_r;
      clr_nxt = 1'b0;
      if (wr_presc) begin
         cs_nxt = hwdata[t1pre_pkg::T1PRE_CS_MSB:0];
         dt_nxt = hwdata[t1pre_pkg::T1PRE_DT_HI_BIT:t1pre_pkg::T1PRE_DT_LO_BIT];
         clr_nxt = hwdata[t1pre_pkg::T1PRE_CLR_BIT];
      end
      if (wr_pll) begin
         lsm_nxt = hwdata[t1pre_pkg::T1PRE_LSM_BIT];
         pll_enable_bit_nxt = hwdata[t1pre_pkg::T1PRE_PLL_ENABLE_BIT_BIT];
         fsel_nxt = hwdata[t1pre_pkg::T1PRE_FSEL_BIT] & pll_en_any;
      end else if (!pll_en_any) begin
         fsel_nxt = 1'b0;
      end
   end

   // read data is built from next values so a read right after a write sees it
   always_comb begin
      hrdata_nxt = 32'h00000000;
      if (ap_nxt.valid && !ap_nxt.write) begin
         if (ap_nxt.hit_presc) begin
            hrdata_nxt[t1pre_pkg::T1PRE_CS_MSB:0] = cs_nxt;
            hrdata_nxt[t1pre_pkg::T1PRE_DT_HI_BIT:t1pre_pkg::T1PRE_DT_LO_BIT] = dt_nxt;
         end else if (ap_nxt.hit_pll) begin
            hrdata_nxt[t1pre_pkg::T1PRE_LSM_BIT] = lsm_nxt;
            hrdata_nxt[t1pre_pkg::T1PRE_FSEL_BIT] = fsel_nxt;
            hrdata_nxt[t1pre_pkg::T1PRE_PLL_ENABLE_BIT_BIT] = pll_enable_bit_nxt | fuse_pll;
            hrdata_nxt[t1pre_pkg::T1PRE_LOCK_BIT] = pll_lock_flag;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_r <= '0;
         hrdata_r <= 32'h00000000;
         cs_r <= t1pre_pkg::T1PRE_PRESC_RST[t1pre_pkg::T1PRE_CS_MSB:0];
         dt_r <= t1pre_pkg::T1PRE_PRESC_RST[t1pre_pkg::T1PRE_DT_HI_BIT:t1pre_pkg::T1PRE_DT_LO_BIT];
         clr_r <= t1pre_pkg::T1PRE_PRESC_RST[t1pre_pkg::T1PRE_CLR_BIT];
         lsm_r <= t1pre_pkg::T1PRE_PLL_RST[t1pre_pkg::T1PRE_LSM_BIT];
         fsel_r <= t1pre_pkg::T1PRE_PLL_RST[t1pre_pkg::T1PRE_FSEL_BIT];
         pll_enable_bit_r <= t1pre_pkg::T1PRE_PLL_RST[t1pre_pkg::T1PRE_PLL_ENABLE_BIT_BIT];
      end else begin
         ap_r <= ap_nxt;
         hrdata_r <= hrdata_nxt;
         cs_r <= cs_nxt;
         dt_r <= dt_nxt;
         clr_r <= clr_nxt;
         lsm_r <= lsm_nxt;
         fsel_r <= fsel_nxt;
         pll_enable_bit_r <= pll_enable_bit_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign dead_time_prescale = dt_r;

   // ---------------- pll control ----------------
   // the lock detector is analog and unrelated to hclk
   t1pre_sync2 #(
      .W(1)
   ) u_lock_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(pll_locked_raw),
      .q(lock_sync)
   );

   assign pll_lock_flag = lock_sync & pll_en_any;
   assign pll_run = pll_en_any;
   // with fuses on the pll the reference oscillator already runs
   assign rc_osc_enable = pll_enable_bit_r & ~fuse_pll;

   // ---------------- clock source switch ----------------
   // a change of source passes a drain cycle with the prescaler held clear,
   // trading one lost base tick for a clean tick stream
   always_comb begin
      sw_nxt = sw_r;
      mode_nxt = mode_r;
      case (sw_r)
         t1pre_pkg::T1PRE_RUN: begin
            if (fsel_r != mode_r) begin
               sw_nxt = t1pre_pkg::T1PRE_DRAIN;
            end
         end
         t1pre_pkg::T1PRE_DRAIN: begin
            mode_nxt = fsel_r;
            sw_nxt = t1pre_pkg::T1PRE_RUN;
         end
         default: begin
            sw_nxt = t1pre_pkg::T1PRE_RUN;
         end
      endcase
   end

   // low speed mode drops every other fast strobe
   assign half_nxt = fast_periph_timebase ? ~half_r : half_r;
   assign pck_eff = fast_periph_timebase & (~lsm_r | half_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_r <= t1pre_pkg::T1PRE_RUN;
         mode_r <= 1'b0;
         half_r <= 1'b0;
      end else begin
         sw_r <= sw_nxt;
         mode_r <= mode_nxt;
         half_r <= half_nxt;
      end
   end

   assign base_tick = (sw_r == t1pre_pkg::T1PRE_RUN) & (mode_r ? pck_eff : 1'b1);
   assign presc_clear = clr_r | (sw_r == t1pre_pkg::T1PRE_DRAIN);

   t1pre_divider #(
      .PRESC_W(PRESC_W),
      .CS_W(CS_W)
   ) u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .base_tick(base_tick),
      .clear(presc_clear),
      .sel(cs_r),
      .tick(div_tick)
   );

   always_comb begin
      timer_clk.tick = div_tick;
      timer_clk.async_mode = mode_r;
      timer_clk.stopped = (cs_r == t1pre_pkg::T1PRE_CS_STOP);
   end

   // ---------------- assertions ----------------
   property p_pll_res_zero;
      @(posedge hclk) disable iff (!hresetn)
      ap_r.valid && !ap_r.write && ap_r.hit_pll |-> hrdata[6:3] == 4'h0;
   endproperty
   a_pll_res_zero: assert property (p_pll_res_zero) else $error("reserved pll bits not zero");

   property p_fsel_needs_pll;
      @(posedge hclk) disable iff (!hresetn)
      $rose(fsel_r) |-> $past(pll_en_any);
   endproperty
   a_fsel_needs_pll: assert property (p_fsel_needs_pll) else $error("fast select set with pll off");

   property p_clr_reads_zero;
      @(posedge hclk) disable iff (!hresetn)
      ap_r.valid && !ap_r.write && ap_r.hit_presc |-> hrdata[7:6] == 2'h0;
   endproperty
   a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("clear or reserved bit read nonzero");

   property p_clr_self;
      @(posedge hclk) disable iff (!hresetn)
      wr_presc && hwdata[6] |=> clr_r ##1 (!clr_r || $past(wr_presc && hwdata[6]));
   endproperty
   a_clr_self: assert property (p_clr_self) else $error("prescaler clear did not self clear");

   property p_pll_enable_bit_fuse;
      @(posedge hclk) disable iff (!hresetn)
      ap_r.valid && !ap_r.write && ap_r.hit_pll && fuse_pll && $past(fuse_pll) |-> hrdata[1];
   endproperty
   a_pll_enable_bit_fuse: assert property (p_pll_enable_bit_fuse) else $error("pll enable not forced to one");

   property p_lsm_half;
      @(posedge hclk) disable iff (!hresetn)
      lsm_r && fast_periph_timebase && pck_eff ##1 (!fast_periph_timebase) [*2] ##1 lsm_r && fast_periph_timebase |-> !pck_eff;
   endproperty
   a_lsm_half: assert property (p_lsm_half) else $error("low speed did not halve the fast clock");

   property p_stopped;
      @(posedge hclk) disable iff (!hresetn)
      cs_r == 4'h0 && $past(cs_r) == 4'h0 |-> !timer_clk.tick;
   endproperty
   a_stopped: assert property (p_stopped) else $error("tick while stopped");

   property p_sync_full;
      @(posedge hclk) disable iff (!hresetn)
      sw_r == t1pre_pkg::T1PRE_RUN && !mode_r && cs_r == 4'h1 && !presc_clear |=> timer_clk.tick;
   endproperty
   a_sync_full: assert property (p_sync_full) else $error("undivided system clock tick missing");

   property p_switch_clean;
      @(posedge hclk) disable iff (!hresetn)
      $changed(mode_r) |-> !timer_clk.tick && $past(presc_clear);
   endproperty
   a_switch_clean: assert property (p_switch_clean) else $error("tick across a source switch");

   property p_lock_sync;
      @(posedge hclk) disable iff (!hresetn)
      $rose(pll_lock_flag) && $stable(pll_en_any) |-> $past(pll_locked_raw, 2);
   endproperty
   a_lock_sync: assert property (p_lock_sync) else $error("lock flag not from synchronised input");

   property p_rc_osc;
      @(posedge hclk) disable iff (!hresetn)
      pll_enable_bit_r && !fuse_pll |-> rc_osc_enable && pll_run;
   endproperty
   a_rc_osc: assert property (p_rc_osc) else $error("pll enable did not start oscillator");

endmodule : t1pre_top

/* core/t1pre_pkg.sv */
// package of the timer1 prescaler and fast clock control block
// assumes a 32-bit ahb-lite register bus and a single 50 MHz system clock
package t1pre_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] T1PRE_PRESC_IDX = 8'h2f;
   localparam logic [7:0] T1PRE_PLL_IDX = 8'h30;
   localparam logic [31:0] T1PRE_PRESC_ADDR = {22'h000000, T1PRE_PRESC_IDX, 2'h0};
   localparam logic [31:0] T1PRE_PLL_ADDR = {22'h000000, T1PRE_PLL_IDX, 2'h0};

   // reset values
   localparam logic [7:0] T1PRE_PRESC_RST = 8'h00;
   localparam logic [7:0] T1PRE_PLL_RST = 8'h00;

   // timer1_prescale_control fields
   localparam int T1PRE_CLR_BIT = 6;
   localparam int T1PRE_DT_HI_BIT = 5;
   localparam int T1PRE_DT_LO_BIT = 4;
   localparam int T1PRE_CS_MSB = 3;

   // pll_control_status fields
   localparam int T1PRE_LSM_BIT = 7;
   localparam int T1PRE_RES_MSB = 6;
   localparam int T1PRE_RES_LSB = 3;
   localparam int T1PRE_FSEL_BIT = 2;
   localparam int T1PRE_PLL_ENABLE_BIT_BIT = 1;
   localparam int T1PRE_LOCK_BIT = 0;

   // clock source fuse code that selects the pll as system clock
   localparam logic [3:0] T1PRE_FUSE_PLL = 4'h1;
   localparam logic [3:0] T1PRE_CS_STOP = 4'h0;
   localparam int T1PRE_CS_W = 4;
   localparam int T1PRE_PRESC_W = 14;

   // latched ahb address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic hit_presc;
      logic hit_pll;
   } t1pre_aphase_t;

   // timer clock bundle towards the counter core
   typedef struct packed {
      logic tick;
      logic async_mode;
      logic stopped;
   } t1pre_tclk_t;

   typedef enum logic {
      T1PRE_RUN,
      T1PRE_DRAIN
   } t1pre_sw_t;

endpackage : t1pre_pkg

/* core/t1pre_sync2.sv */
// two flip-flop level synchroniser
// assumes the input is a level from an unrelated source
`timescale 1ns/1ps
module t1pre_sync2 #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds the second stage only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;

endmodule : t1pre_sync2

/* core/t1pre_divider.sv */
// power-of-two prescaler with stop setting and synchronous clear
// assumes base_tick is a one-cycle strobe synchronous to hclk
`timescale 1ns/1ps
module t1pre_divider #(
   parameter int PRESC_W = t1pre_pkg::T1PRE_PRESC_W,
   parameter int CS_W = t1pre_pkg::T1PRE_CS_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic base_tick,
   input wire logic clear,
   input wire logic [CS_W-1:0] sel,
   output logic tick
);
   logic [PRESC_W-1:0] cnt_r;
   logic [PRESC_W-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // the top code must reach exactly the top counter bit
   if ((1 << CS_W) - 2 != PRESC_W) begin : g_chk
      $error("t1pre_divider: PRESC_W must equal 2**CS_W-2");
   end

   // code n taps when the low n-1 counter bits are all ones
   function automatic logic tap_hit(input logic [CS_W-1:0] s, input logic [PRESC_W-1:0] c);
      logic hit;
      hit = (s != '0);
      for (int i = 0; i < PRESC_W; i++) begin
         if (i < int'(s) - 1) begin
            hit = hit & c[i];
         end
      end
      return hit;
   endfunction : tap_hit

   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (clear) begin
         cnt_nxt = '0;
      end else if (base_tick) begin
         cnt_nxt = cnt_r + PRESC_W'(1);
         tick_nxt = tap_hit(sel, cnt_r);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

endmodule : t1pre_divider

/* testbench/tb_t1pre_top.sv */
// self-checking bench for the timer1 prescaler and fast clock control block
// assumes the ahb-lite slave answers with zero wait states and hready looped from hreadyout
`timescale 1ns/1ps
module tb_t1pre_top;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [3:0] clock_source_fuses;
   logic pll_locked_raw;
   logic fast_periph_timebase;
   logic pll_run;
   logic rc_osc_enable;
   logic [1:0] dead_time_prescale;
   t1pre_pkg::t1pre_tclk_t timer_clk;
   logic rd_dp;
   logic [31:0] exp_q[$];
   int mismatches;
   int n_tests;
   int fcnt;
   int seed;
   int code;
   localparam logic [31:0] PRESC = t1pre_pkg::T1PRE_PRESC_ADDR;
   localparam logic [31:0] PLL = t1pre_pkg::T1PRE_PLL_ADDR;

   t1pre_top uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .clock_source_fuses(clock_source_fuses), .pll_locked_raw(pll_locked_raw),
      .fast_periph_timebase(fast_periph_timebase), .pll_run(pll_run), .rc_osc_enable(rc_osc_enable),
      .dead_time_prescale(dead_time_prescale), .timer_clk(timer_clk)
   );

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // one single transfer; address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_dp <= ~w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h000000, d});
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [7:0] exp);
      exp_q.push_back({24'h000000, exp});
      bus(1'b0, a, 32'h00000000);
   endtask : rd

   // read data is compared at the edge that closes the data phase
   always @(posedge hclk) begin
      if (rd_dp === 1'b1) begin
         check("hrdata", hrdata, exp_q.pop_front());
         check("hresp", {31'h0, hresp}, 32'h0);
      end
   end

   // fast clock strobe every third system cycle
   always @(posedge hclk) begin
      fcnt <= (fcnt == 2) ? 0 : fcnt + 1;
      fast_periph_timebase <= (fcnt == 2);
   end

   // skips two ticks so a leftover prescaler state cannot shorten the measured gap
   task automatic period(input int exp);
      int n;
      n = 0;
      repeat (2) begin
         do begin
            @(posedge hclk);
            n++;
         end while (timer_clk.tick !== 1'b1 && n < 40000);
      end
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (timer_clk.tick !== 1'b1 && n < 40000);
      check("tick period", 32'(n), 32'(exp));
   endtask : period

   initial begin
      // slowest tap run plus the lock wait need about 55k cycles; this allows 80k
      #1600000;
      mismatches++;
      give_verdict();
   end

   initial begin
      seed = 32'h89a453a6;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      clock_source_fuses = 4'h3;
      pll_locked_raw = 1'b0;
      fast_periph_timebase = 1'b0;
      fcnt = 0;
      rd_dp = 1'b0;
      mismatches = 0;
      n_tests = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      check("stopped", {31'h0, timer_clk.stopped}, 32'h1);
      check("async_mode", {31'h0, timer_clk.async_mode}, 32'h0);
      rd(PRESC, 8'h00);
      rd(PLL, 8'h00);
      rd(32'h000000c4, 8'h00);
      // stopped setting gives no tick
      code = 0;
      repeat (60) begin
         @(posedge hclk);
         if (timer_clk.tick === 1'b1) code++;
      end
      check("stopped ticks", 32'(code), 32'h0);
      wr(PRESC, 8'hff);
      rd(PRESC, 8'h3f);
      check("dead_time", {30'h0, dead_time_prescale}, 32'h3);
      for (int c = 1; c <= 5; c++) begin
         wr(PRESC, 8'(c));
         period(1 << (c - 1));
      end
      code = 6 + ($unsigned($random(seed)) % 10);
      wr(PRESC, 8'(code));
      period(1 << (code - 1));
      // prescaler clear: self-clearing and ignored on read
      wr(PRESC, 8'h43);
      rd(PRESC, 8'h03);
      period(4);
      // fast select refused while the pll is off
      wr(PRESC, 8'h00);
      wr(PLL, 8'h04);
      rd(PLL, 8'h00);
      check("async_mode", {31'h0, timer_clk.async_mode}, 32'h0);
      wr(PLL, 8'h02);
      @(posedge hclk);
      check("pll_run", {31'h0, pll_run}, 32'h1);
      check("rc_osc", {31'h0, rc_osc_enable}, 32'h1);
      // lock may chatter during lock-in; software ignores it for 100 us
      repeat (4995) begin
         @(posedge hclk);
         pll_locked_raw <= 1'($random(seed));
      end
      @(posedge hclk);
      pll_locked_raw <= 1'b1;
      repeat (4) @(posedge hclk);
      rd(PLL, 8'h03);
      wr(PLL, 8'h7e);
      rd(PLL, 8'h07);
      wr(PRESC, 8'h01);
      repeat (3) @(posedge hclk);
      check("async_mode", {31'h0, timer_clk.async_mode}, 32'h1);
      period(3);
      // low speed halves the fast clock; timer stopped around the change
      wr(PRESC, 8'h00);
      wr(PLL, 8'h86);
      wr(PRESC, 8'h01);
      rd(PLL, 8'h87);
      period(6);
      wr(PRESC, 8'h00);
      wr(PLL, 8'h00);
      rd(PLL, 8'h00);
      repeat (3) @(posedge hclk);
      check("async_mode", {31'h0, timer_clk.async_mode}, 32'h0);
      wr(PRESC, 8'h01);
      period(1);
      // pll as system clock forces the enable bit
      @(posedge hclk);
      clock_source_fuses <= t1pre_pkg::T1PRE_FUSE_PLL;
      repeat (4) @(posedge hclk);
      check("pll_run", {31'h0, pll_run}, 32'h1);
      check("rc_osc", {31'h0, rc_osc_enable}, 32'h0);
      rd(PLL, 8'h03);
      wr(PRESC, 8'h00);
      wr(PLL, 8'h04);
      rd(PLL, 8'h07);
      repeat (2) @(posedge hclk);
      give_verdict();
   end
endmodule : tb_t1pre_top
